/* bcd_cnt_if.sv */
// Purpose: link between the calendar logic and one bcd counter
// Assumes: single sys_clk domain
// Notes:   ctrl side drives increment and load, cnt side returns value and carry
`default_nettype none
interface bcd_cnt_if;
  logic       inc;
  logic       load;
  logic [7:0] load_val;
  logic [7:0] min_val;
  logic [7:0] max_val;
  logic [7:0] value;
  logic       carry;
  modport ctrl (output inc, load, load_val, min_val, max_val, input value, carry);
  modport cnt  (input inc, load, load_val, min_val, max_val, output value, carry);
endinterface
`default_nettype wire

/* bcd_counter.sv */
// Purpose: one two-digit bcd counter with wrap range and carry out
// Assumes: load has priority over increment
// Notes:   carry is combinational, high when incrementing at the top value
`default_nettype none
module bcd_counter #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // counter link
  bcd_cnt_if.cnt   port
);
  logic [7:0] next_value;

  always_comb begin
    if (port.value == port.max_val) begin
      next_value = port.min_val;
    end else if (port.value[3:0] == 4'h9) begin
      next_value = {port.value[7:4] + 4'h1, 4'h0};
    end else begin
      next_value = {port.value[7:4], port.value[3:0] + 4'h1};
    end
  end

  assign port.carry = port.inc && (port.value == port.max_val);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      port.value <= RESET_VAL;
    end else if (port.load) begin
      port.value <= port.load_val;
    end else if (port.inc) begin
      port.value <= next_value;
    end
  end
endmodule
`default_nettype wire

/* host_bus.sv */
// Purpose: host master on the bytewide port
// Assumes: strobes change at falling edge
// Notes:   released data lines show inverse of last value
`default_nettype none
module host_bus (
  // clock and read data
  input  wire logic        sys_clk,
  input  wire logic [7:0]  rd_data,
  // strobes and write data
  output logic      [10:0] addr,
  output logic             cs_n,
  output logic             oe_n,
  output logic             we_n,
  output logic      [7:0]  wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 11'h000;
    {cs_n, oe_n, we_n} = 3'h7;
    wr_data = 8'h00;
  end
  // write held four cycles; address set a cycle ahead, data held a cycle after
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wr_data = d;
    @(negedge sys_clk);
    {cs_n, we_n} = 2'h0;
    repeat (4) @(negedge sys_clk);
    {cs_n, we_n} = 2'h3;
    @(negedge sys_clk);
    wr_data = ~d;
  endtask
  // read sampled twice, four cycles apart
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic [7:0] d2);
    @(negedge sys_clk);
    addr = a;
    {cs_n, oe_n} = 2'h0;
    repeat (4) @(negedge sys_clk);
    d = rd_data;
    repeat (4) @(negedge sys_clk);
    d2 = rd_data;
    {cs_n, oe_n} = 2'h3;
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* nv_rtc_ram.sv */
// Purpose: bytewide battery-backed ram with double-buffered bcd calendar clock
// Assumes: strobes, address and data come from pins and are synchronised here
// Notes:   user copy follows the counters every cycle unless halted or powered down
`default_nettype none
module nv_rtc_ram
  import rtc_pkg::*;
#(
  parameter int SUB_COUNT = SUB_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // memory port
  input  wire logic [10:0] addr_bus,
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  data_bus_in,
  output logic      [7:0]  data_bus_out,
  output logic             data_bus_oe,
  // supply and battery monitors
  input  wire logic        power_ok,
  input  wire logic        battery_good
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 24;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [10:0]       addr;
  logic              cs;
  logic              oe;
  logic              we;
  logic [7:0]        wdata;
  logic              pwr;
  logic              batt;

  always_ff @(posedge sys_clk) begin
    sync_a <= {addr_bus, ~cs_n, ~oe_n, ~we_n, data_bus_in, power_ok, battery_good};
    sync_b <= sync_a;
  end
  assign {addr, cs, oe, we, wdata, pwr, batt} = sync_b;

  logic       rd_act;
  logic       wr_act;
  logic       is_clk;
  logic [2:0] idx;
  assign rd_act = pwr && cs && oe && !we;
  assign wr_act = pwr && cs && we;
  assign is_clk = (addr >= CLK_BASE);
  assign idx    = addr[2:0];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] user [8];
  logic [7:0] cnt_val [8];
  logic       cnt_carry [8];
  logic       cnt_inc [8];
  logic [7:0] cnt_max [8];

  logic rd_halt;
  logic wr_halt;
  logic wr_halt_q;
  logic osc_stop;
  logic freq_test;
  logic halt_fall;
  logic upd_en;
  assign rd_halt   = user[LOC_CENT][RD_HALT_BIT];
  assign wr_halt   = user[LOC_CENT][WR_HALT_BIT];
  assign osc_stop  = user[LOC_SEC][OSC_STOP_BIT];
  assign freq_test = user[LOC_WDAY][FT_BIT];
  assign halt_fall = wr_halt_q && !wr_halt;
  assign upd_en    = pwr && !rd_halt && !wr_halt && !halt_fall;

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  logic [16:0] sub_cnt;
  logic [9:0]  sec_cnt;
  logic        sub_tick;
  logic        sec_tick;
  logic        toggle_512;
  assign sub_tick = !osc_stop && (sub_cnt == 17'(SUB_COUNT - 1));
  assign sec_tick = sub_tick && (sec_cnt == 10'(SUB_PER_SEC - 1));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sub_cnt    <= 17'h0;
      sec_cnt    <= 10'h0;
      toggle_512 <= 1'b0;
    end else if (!osc_stop) begin
      if (sub_tick) begin
        sub_cnt    <= 17'h0;
        sec_cnt    <= sec_cnt + 10'h1;
        toggle_512 <= ~toggle_512;
      end else begin
        sub_cnt <= sub_cnt + 17'h1;
      end
    end
  end

  // ----------------------------------------
  // calendar counters
  // ----------------------------------------
  function automatic logic bcd_div4(input logic [7:0] b);
    if (b[4] == 1'b0) begin
      bcd_div4 = (b[3:0] == 4'h0) || (b[3:0] == 4'h4) || (b[3:0] == 4'h8);
    end else begin
      bcd_div4 = (b[3:0] == 4'h2) || (b[3:0] == 4'h6);
    end
  endfunction

  logic       leap;
  logic [7:0] month_len;
  always_comb begin
    if (cnt_val[LOC_YEAR] == 8'h00) begin
      leap = bcd_div4(cnt_val[LOC_CENT]);
    end else begin
      leap = bcd_div4(cnt_val[LOC_YEAR]);
    end
    case (cnt_val[LOC_MONTH])
      8'h02:                      month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default:                    month_len = 8'h31;
    endcase
  end

  always_comb begin
    cnt_inc[LOC_SEC]   = sec_tick;
    cnt_inc[LOC_MIN]   = cnt_carry[LOC_SEC];
    cnt_inc[LOC_HOUR]  = cnt_carry[LOC_MIN];
    cnt_inc[LOC_WDAY]  = cnt_carry[LOC_HOUR];
    cnt_inc[LOC_DATE]  = cnt_carry[LOC_HOUR];
    cnt_inc[LOC_MONTH] = cnt_carry[LOC_DATE];
    cnt_inc[LOC_YEAR]  = cnt_carry[LOC_MONTH];
    cnt_inc[LOC_CENT]  = cnt_carry[LOC_YEAR];
    for (int k = 0; k < 8; k++) begin
      cnt_max[k] = BCD_MAXS[k*8 +: 8];
    end
    cnt_max[LOC_DATE] = month_len;
  end

  bcd_cnt_if cif [8] ();

  for (genvar k = 0; k < 8; k++) begin : g_cnt
    assign cif[k].inc      = cnt_inc[k];
    assign cif[k].load     = halt_fall;
    assign cif[k].load_val = user[k] & BCD_MASKS[k*8 +: 8];
    assign cif[k].min_val  = BCD_MINS[k*8 +: 8];
    assign cif[k].max_val  = cnt_max[k];
    assign cnt_val[k]      = cif[k].value;
    assign cnt_carry[k]    = cif[k].carry;
    bcd_counter #(
      .RESET_VAL (RESET_VALS[k*8 +: 8])
    ) u_cnt (
      .sys_clk (sys_clk),
      .srst    (srst),
      .port    (cif[k])
    );
  end

  // ----------------------------------------
  // user copy and ram writes
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_halt_q <= 1'b0;
    end else begin
      wr_halt_q <= wr_halt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int k = 0; k < 8; k++) begin
        user[k] <= RESET_VALS[k*8 +: 8];
      end
    end else begin
      if (upd_en) begin
        for (int k = 0; k < 8; k++) begin
          user[k] <= (user[k] & ~BCD_MASKS[k*8 +: 8])
                   | (cnt_val[k] & BCD_MASKS[k*8 +: 8]);
        end
      end
      if (wr_act && is_clk) begin
        user[idx] <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_act && !is_clk) begin
      ram[addr] <= wdata;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rbyte;
  always_comb begin
    rbyte = user[idx];
    if (idx == LOC_WDAY) begin
      rbyte[BF_BIT] = batt;
    end
    if (idx == LOC_SEC && freq_test && !osc_stop) begin
      rbyte[0] = toggle_512;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_bus_out <= 8'h00;
    end else if (rd_act) begin
      data_bus_out <= is_clk ? rbyte : ram[addr];
    end
  end

  assign data_bus_oe = rd_act;
endmodule
`default_nettype wire

/* nv_rtc_ram_sva.sv */
// Purpose: port checks for the timekeeping ram
// Assumes: strobes pass two sync flops
// Notes:   bound to every nv_rtc_ram
`default_nettype none
module nv_rtc_ram_sva (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [10:0] addr_bus,
  input wire logic        cs_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [7:0]  data_bus_in,
  input wire logic [7:0]  data_bus_out,
  input wire logic        data_bus_oe,
  input wire logic        power_ok,
  input wire logic        battery_good
);
  logic rd_now;
  assign rd_now = !cs_n && !oe_n && we_n && power_ok && !srst;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_read_drives_bus: assert property (rd_now [*3] |-> data_bus_oe)
    else $error("no drive on read");
  a_deselect_quiet: assert property (cs_n [*3] |-> !data_bus_oe)
    else $error("drive while deselected");
  a_power_fail_quiet: assert property ((!power_ok) [*3] |-> !data_bus_oe)
    else $error("drive in power fail");
  a_write_no_drive: assert property ((!cs_n && !we_n) [*3] |-> !data_bus_oe)
    else $error("drive during write");
  a_idle_holds_data: assert property ((cs_n && !srst) [*4] |=> $stable(data_bus_out))
    else $error("data moved while idle");
  a_battery_shown: assert property ((rd_now && addr_bus == 11'h7fc && $stable(battery_good)) [*4]
    |-> data_bus_out[7] == battery_good)
    else $error("battery flag wrong");
  a_hour_bcd_range: assert property ((rd_now && addr_bus == 11'h7fb) [*4]
    |-> data_bus_out[5:0] <= 6'h23 && data_bus_out[3:0] <= 4'h9)
    else $error("hour out of range");
  a_min_bcd_range: assert property ((rd_now && addr_bus == 11'h7fa) [*4]
    |-> data_bus_out[6:0] <= 7'h59 && data_bus_out[3:0] <= 4'h9)
    else $error("minute out of range");
  c_read: cover property (rd_now [*4]);
  c_write: cover property ((!cs_n && !we_n && power_ok) [*3]);
  c_power_fail: cover property (!power_ok && !cs_n);
endmodule
bind nv_rtc_ram nv_rtc_ram_sva u_nv_rtc_ram_sva (.sys_clk(sys_clk), .srst(srst),
  .addr_bus(addr_bus), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .data_bus_in(data_bus_in),
  .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .power_ok(power_ok),
  .battery_good(battery_good));
`default_nettype wire

/* rtc_pkg.sv */
// Purpose: constants shared by the bytewide timekeeping ram
// Assumes: 100 MHz sys_clk, synchronous active-high srst
// Notes:   packed 64-bit tables hold one byte per clock location, index 0 at the bottom
//
// Behaviour
// - memory is 2048 bytes; clock registers sit at the eight top addresses
// - clock locations use the same port and strobes as plain ram
// - century to seconds held as bcd, hours in 24-hour form
// - month lengths and leap days handled, correct through year 2100
// - user copy kept apart from counters; counters keep running meanwhile
// - read-halt bit 6 of century byte suspends user updates
// - during read halt user copy holds time current when halt was set
// - on halt release all user registers refresh together within one second
// - write-halt bit 7 of century byte suspends updates for loading time
// - clearing write halt copies user values into counters; counting resumes
// - seconds bit 7 stops the oscillator when 1, writable any time
// - weekday bit 6 with oscillator running toggles seconds lsb at 512 Hz
// - reading seconds under frequency test shows bit 0 toggling at 512 Hz
// - supply out of tolerance deselects device, ignores access and updates
// - read when chip select and output enable low, write enable high
// - write while chip select and write enable low; address held stable
// - century 7f8, seconds 7f9 up to year 7ff
// - weekday bit 7 reads battery good, writes to it ignored
`default_nettype none
package rtc_pkg;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          SUB_HZ         = 1024;
  localparam int          SUB_CYCLES     = CLK_HZ / SUB_HZ;
  localparam int          SUB_PER_SEC    = 1024;
  localparam int          ADDR_W         = 11;
  localparam int          RAM_DEPTH      = 2048;
  localparam logic [10:0] CLK_BASE       = 11'h7f8;
  localparam logic [2:0]  LOC_CENT       = 3'h0;
  localparam logic [2:0]  LOC_SEC        = 3'h1;
  localparam logic [2:0]  LOC_MIN        = 3'h2;
  localparam logic [2:0]  LOC_HOUR       = 3'h3;
  localparam logic [2:0]  LOC_WDAY       = 3'h4;
  localparam logic [2:0]  LOC_DATE       = 3'h5;
  localparam logic [2:0]  LOC_MONTH      = 3'h6;
  localparam logic [2:0]  LOC_YEAR       = 3'h7;
  localparam int          WR_HALT_BIT    = 7;
  localparam int          RD_HALT_BIT    = 6;
  localparam int          OSC_STOP_BIT   = 7;
  localparam int          FT_BIT         = 6;
  localparam int          BF_BIT         = 7;
  localparam logic [63:0] BCD_MASKS      = 64'hff1f3f073f7f7f3f;
  localparam logic [63:0] BCD_MINS       = 64'h0001010100000000;
  localparam logic [63:0] BCD_MAXS       = 64'h9912310723595939;
  localparam logic [63:0] RESET_VALS     = 64'h0001010100000020;
endpackage
`default_nettype wire

/* test_nv_rtc_ram.sv */
// Purpose: self-checking bench for the timekeeping ram
// Assumes: one second is 4096 cycles with SUB_COUNT 4
// Notes:   host_bus makes all port cycles
`default_nettype none
module test_nv_rtc_ram;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, srst, cs_n, oe_n, we_n, data_bus_oe, power_ok, battery_good;
  logic [10:0] addr_bus;
  logic [7:0]  data_bus_in, data_bus_out, d, d2, d3;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  nv_rtc_ram #(.SUB_COUNT(4)) u_nv_rtc_ram (.sys_clk(sys_clk), .srst(srst),
    .addr_bus(addr_bus), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .power_ok(power_ok),
    .battery_good(battery_good));
  host_bus u_host_bus (.sys_clk(sys_clk), .rd_data(data_bus_out), .addr(addr_bus),
    .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .wr_data(data_bus_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic t_ram;
    u_host_bus.rd(CLK_BASE, d, d2);
    chk(d, 8'h20);
    u_host_bus.rd(11'h7fe, d, d2);
    chk(d, 8'h01);
    u_host_bus.wr(11'h000, 8'ha5);
    u_host_bus.wr(11'h7f7, 8'h3c);
    u_host_bus.rd(11'h000, d, d2);
    chk(d, 8'ha5);
    u_host_bus.rd(11'h7f7, d, d2);
    chk(d, 8'h3c);
    $display("test ram done");
  endtask
  task automatic t_leap;
    u_host_bus.wr(CLK_BASE, 8'ha0);
    u_host_bus.wr(11'h7fe, 8'h02);
    u_host_bus.wr(11'h7fd, 8'h28);
    u_host_bus.wr(11'h7fb, 8'h23);
    u_host_bus.wr(11'h7fa, 8'h59);
    u_host_bus.wr(11'h7f9, 8'h59);
    u_host_bus.wr(CLK_BASE, 8'h20);
    wait_cyc(4200);
    u_host_bus.wr(CLK_BASE, 8'h60);
    u_host_bus.rd(11'h7fd, d, d2);
    chk(d, 8'h29);
    u_host_bus.rd(11'h7fb, d, d2);
    chk(d, 8'h00);
    u_host_bus.rd(11'h7fa, d, d2);
    chk(d, 8'h00);
    u_host_bus.rd(11'h7fc, d, d2);
    chk(d & 8'hc7, 8'h82);
    $display("test leap done");
  endtask
  task automatic t_halt;
    u_host_bus.rd(11'h7f9, d, d2);
    wait_cyc(4200);
    u_host_bus.rd(11'h7f9, d3, d2);
    chk(d3, d);
    u_host_bus.wr(CLK_BASE, 8'h20);
    wait_cyc(5000);
    u_host_bus.wr(CLK_BASE, 8'h60);
    u_host_bus.rd(11'h7f9, d3, d2);
    chk({7'h00, d3 != d}, 8'h01);
    u_host_bus.wr(CLK_BASE, 8'h20);
    $display("test halt done");
  endtask
  task automatic t_osc;
    u_host_bus.wr(CLK_BASE, 8'ha0);
    u_host_bus.wr(11'h7f9, 8'h80);
    u_host_bus.wr(CLK_BASE, 8'h20);
    wait_cyc(5000);
    u_host_bus.rd(11'h7f9, d, d2);
    chk(d, 8'h80);
    u_host_bus.wr(11'h7f9, 8'h00);
    u_host_bus.wr(11'h7fc, 8'h40);
    u_host_bus.rd(11'h7f9, d, d2);
    chk({7'h00, d[0] ^ d2[0]}, 8'h01);
    // test bit stays still once the oscillator stops
    u_host_bus.wr(11'h7f9, 8'h80);
    u_host_bus.rd(11'h7f9, d, d2);
    chk({7'h00, d[0] ^ d2[0]}, 8'h00);
    u_host_bus.wr(11'h7f9, 8'h00);
    u_host_bus.wr(11'h7fc, 8'h00);
    $display("test oscillator done");
  endtask
  task automatic t_power;
    power_ok = 1'b0;
    u_host_bus.wr(11'h000, 8'h5a);
    power_ok = 1'b1;
    wait_cyc(3);
    u_host_bus.rd(11'h000, d, d2);
    chk(d, 8'ha5);
    battery_good = 1'b0;
    u_host_bus.wr(11'h7fc, 8'hbf);
    u_host_bus.rd(11'h7fc, d, d2);
    chk({7'h00, d[7]}, 8'h00);
    battery_good = 1'b1;
    $display("test power done");
  endtask
  initial begin
    srst = 1'b1;
    power_ok = 1'b1;
    battery_good = 1'b1;
    wait_cyc(5);
    srst = 1'b0;
    wait_cyc(2);
    t_ram();
    t_leap();
    t_halt();
    t_osc();
    t_power();
    end_sim();
  end
endmodule
`default_nettype wire
